// file: design/bstx_top.sv
// Local design decisions: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// Contract
// R1: On last buffer, send block check then reset generator if asked, else sync or idle.
// R2: Buffer characters enter the block check only when its enable flag is set.
// R3: Check-clear flag clears the block check before the buffer's first character.
// R4: Auto-escape flag sends one DLE ahead of the buffer's data.
// R5: Transparent flag sets transparent mode after the buffer; underrun fills DLE-SYNC.
// R6: Underrun is a non-last buffer finished with no next descriptor ready.
// R7: In transparent mode every outgoing DLE is followed by a second DLE; the code doubles only DLEs from the buffer data.
// R8: Transparent mode always computes CRC16, even when LRC is selected.
// R9: Software presets temporary CRC and arranges DLEs before control characters.
// R10: Clear transparent flag sets normal mode; underrun fills SYNC-SYNC.
// R11: Finished buffer reports underrun and clear-to-send-lost status.
// R12: Software gives a nonzero octet count; exactly that many octets are sent.
// R13: Eight-bit event register, set on events, readable, cleared by reset.
// R14: Writing one clears an event bit, zero leaves it; many at once.
// R15: Interrupt request stays while any unmasked event bit is set.
// R16: Event bits: cts 7, carrier 6, reserved 5, txerr 4, rch 3, busy 2, tx 1, rx 0.
// R17: Clear-to-send or carrier input change sets its change event.
// R18: Clear-to-send loss or underrun sets the transmit error event.
// R19: A received character stored in a buffer sets the character event.
// R20: Character with no buffer is dropped, sets busy, receive stops until hunt.
// R21: Sent buffer sets transmitted event; closed receive buffer sets received event.
// R22: Read-write mask register; one enables the event's interrupt.
// R23: A hardware set wins over a same-cycle software clear.
module bstx_top
  import bstx_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        desc_valid,
  output logic             desc_ready,
  input  wire logic [15:0] desc_length,
  input  wire logic        desc_last,
  input  wire logic        send_check_after_last,
  input  wire logic        desc_check_enable,
  input  wire logic        check_clear_flag,
  input  wire logic        auto_escape_prefix,
  input  wire logic        transparent_flag,
  input  wire logic        data_valid,
  output logic             data_ready,
  input  wire logic [7:0]  data_byte,
  output logic             stat_valid,
  output logic             underrun_status,
  output logic             clear_to_send_lost,
  input  wire logic        tclk,
  output logic             txd,
  output logic             rts_n,
  input  wire logic        cts_n,
  input  wire logic        cd_n,
  input  wire logic        rx_char_stored,
  input  wire logic        rx_char_dropped,
  input  wire logic        rx_buffer_closed,
  input  wire logic        enter_hunt,
  output logic             rx_stopped,
  output logic             irq
);
  import bstx_pkg::*;

  typedef struct packed {
    bstx_st_e    st;
    bstx_st_e    ret;
    logic [2:0]  tclk_s;
    logic [2:0]  cts_s;
    logic [2:0]  cd_s;
    logic [2:0]  bitcnt;
    logic [7:0]  sh;
    logic        txd;
    logic        rts_n;
    logic [7:0]  fill2;
    logic [7:0]  last_byte;
    logic        d_last;
    logic        d_chk;
    logic        d_bcs;
    logic        d_tr;
    logic [15:0] d_cnt;
    logic        pend_dle;
    logic        xmode;
    logic        use_crc;
    logic [15:0] crc;
    logic        un_pend;
    logic        ct_pend;
    logic        stat_valid;
    logic        stat_un;
    logic        stat_ct;
    logic [7:0]  ev;
    logic [7:0]  mask;
    logic [CTRL_W-1:0] ctrl;
    logic [23:0] chars;
    logic        rx_stopped;
    logic        irq;
    logic        aw_got;
    logic [7:0]  aw_addr;
    logic        w_got;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } bstx_regs_s;

  bstx_regs_s  r;
  bstx_regs_s  next_r;
  logic        load;
  logic        accept;
  logic [7:0]  ev_set;
  logic [7:0]  ev_clr;

  function automatic logic [15:0] bstx_crc16(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] x;
    x = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++)
    begin
      x = x[0] ? ((x >> 1) ^ CRC_POLY) : (x >> 1);
    end
    return x;
  endfunction

  function automatic logic [31:0] bstx_merge(input logic [31:0] o, input logic [31:0] w,
                                             input logic [3:0] s);
    logic [31:0] m;
    for (int i = 0; i < 4; i++)
    begin
      m[i*8 +: 8] = {8{s[i]}};
    end
    return (o & ~m) | (w & m);
  endfunction

  assign s_axi_awready      = !r.aw_got && !r.bvalid;
  assign s_axi_wready       = !r.w_got && !r.bvalid;
  assign s_axi_arready      = !r.rvalid;
  assign s_axi_bvalid       = r.bvalid;
  assign s_axi_bresp        = r.bresp;
  assign s_axi_rvalid       = r.rvalid;
  assign s_axi_rdata        = r.rdata;
  assign s_axi_rresp        = r.rresp;
  assign stat_valid         = r.stat_valid;
  assign underrun_status    = r.stat_un;
  assign clear_to_send_lost = r.stat_ct;
  assign txd                = r.txd;
  assign rts_n              = r.rts_n;
  assign rx_stopped         = r.rx_stopped;
  assign irq                = r.irq;

  always_comb
  begin
    logic        fall;
    logic        fin;
    logic [7:0]  tx_b;
    logic [7:0]  dle;
    logic [7:0]  s1;
    logic [7:0]  s2;
    logic [7:0]  fill_a;
    logic [7:0]  fill_b;
    logic [31:0] wr;
    next_r = r;
    fin    = 1'b0;
    fall   = !r.tclk_s[1] && r.tclk_s[2];
    ev_set = 8'h00;
    ev_clr = 8'h00;
    accept = 1'b0;
    data_ready = 1'b0;
    dle    = r.chars[CH_DLE +: 8];
    s1     = r.chars[CH_SYNC1 +: 8];
    s2     = r.chars[CH_SYNC2 +: 8];
    fill_a = r.xmode ? dle : s1;  // [R5] [R10]
    fill_b = r.xmode ? s1 : s2;
    tx_b   = IDLE_CHAR;
    wr     = 32'h0;
    next_r.stat_valid = 1'b0;
    // Line inputs cross domains; only stage two and three feed logic
    next_r.tclk_s = {r.tclk_s[1:0], tclk};
    next_r.cts_s  = {r.cts_s[1:0], cts_n};
    next_r.cd_s   = {r.cd_s[1:0], cd_n};
    load = fall && (r.bitcnt == BIT_LAST);
    desc_ready = load && desc_valid &&
                 ((r.st == S_IDLE && r.ctrl[CTRL_EN]) || r.st == S_NEXT);

    if (load)
    begin
      case (r.st)
        S_IDLE, S_NEXT:
        begin
          if (desc_ready)
          begin
            // Each message opens with a sync pair; a chained buffer opens with the fill pair, DLE-SYNC in transparent mode
            accept = 1'b1;
            next_r.d_last   = desc_last;
            next_r.d_chk    = send_check_after_last;
            next_r.d_bcs    = desc_check_enable;
            next_r.d_tr     = transparent_flag;
            next_r.d_cnt    = desc_length;  // [R12]
            next_r.pend_dle = auto_escape_prefix;  // [R4]
            if (check_clear_flag)
            begin
              next_r.crc = CRC_PRESET;  // [R3]
            end
            tx_b = (r.st == S_IDLE) ? s1 : fill_a;
            next_r.fill2 = (r.st == S_IDLE) ? s2 : fill_b;
            next_r.ret = S_DATA;
            next_r.st  = S_FILL2;
          end
          else if (r.st == S_NEXT)
          begin
            // Descriptor not ready after a non-last buffer
            tx_b = fill_a;  // [R6]
            next_r.fill2 = fill_b;
            next_r.ret = S_NEXT;
            next_r.st  = S_FILL2;
            next_r.un_pend = 1'b1;
            ev_set[EV_TXE] = 1'b1;  // [R18]
          end
          else if (r.ctrl[CTRL_SYNC_FILL_SELECT])
          begin
            tx_b = s1;  // [R1]
            next_r.fill2 = s2;
            next_r.ret = S_IDLE;
            next_r.st  = S_FILL2;
          end
        end
        S_DATA:
        begin
          if (r.pend_dle)
          begin
            tx_b = dle;  // [R4]
            next_r.pend_dle = 1'b0;
          end
          else if (data_valid)
          begin
            tx_b = data_byte;
            data_ready = 1'b1;
            next_r.d_cnt = r.d_cnt - 16'h0001;
            if (r.d_bcs)
            begin
              // Transparent mode forces CRC16 whatever the LRC setting
              next_r.crc = (r.xmode || !r.ctrl[CTRL_LRC]) ?  // [R8]
                           bstx_crc16(r.crc, data_byte) :
                           (r.crc ^ {8'h00, data_byte});  // [R2]
            end
            if (r.xmode && data_byte == dle)
            begin
              next_r.st = S_DUP;  // [R7]
            end
            else if (r.d_cnt == 16'h0001)
            begin
              fin = 1'b1;
            end
          end
          else
          begin
            // Byte stream starved mid-buffer: fill and flag as underrun
            tx_b = fill_a;
            next_r.fill2 = fill_b;
            next_r.ret = S_DATA;
            next_r.st  = S_FILL2;
            next_r.un_pend = 1'b1;
            ev_set[EV_TXE] = 1'b1;  // [R18]
          end
        end
        S_DUP:
        begin
          tx_b = dle;  // [R7]
          if (r.d_cnt == 16'h0000)
          begin
            fin = 1'b1;
          end
          else
          begin
            next_r.st = S_DATA;
          end
        end
        S_CRC1:
        begin
          tx_b = r.crc[7:0];
          if (r.use_crc)
          begin
            next_r.st = S_CRC2;
          end
          else
          begin
            next_r.crc = CRC_PRESET;  // [R1]
            next_r.st  = S_IDLE;
          end
        end
        S_CRC2:
        begin
          tx_b = r.crc[15:8];
          next_r.crc = CRC_PRESET;  // [R1]
          next_r.st  = S_IDLE;
        end
        S_FILL2:
        begin
          tx_b = r.fill2;
          next_r.st = r.ret;
        end
        default:
        begin
          next_r.st = S_IDLE;
        end
      endcase
      next_r.txd       = tx_b[0];
      next_r.sh        = {1'b0, tx_b[7:1]};
      next_r.bitcnt    = 3'h0;
      next_r.last_byte = tx_b;
    end
    else if (fall)
    begin
      next_r.txd    = r.sh[0];
      next_r.sh     = {1'b0, r.sh[7:1]};
      next_r.bitcnt = r.bitcnt + 3'h1;
    end

    if (fin)
    begin
      // Status goes back with the buffer; mode switches only after it
      next_r.stat_valid = 1'b1;
      next_r.stat_un    = next_r.un_pend;  // [R11]
      next_r.stat_ct    = r.ct_pend;
      next_r.un_pend    = 1'b0;
      next_r.ct_pend    = 1'b0;
      next_r.use_crc    = r.xmode || !r.ctrl[CTRL_LRC];
      next_r.xmode      = r.d_tr;  // [R5] [R10]
      ev_set[EV_TX]     = 1'b1;  // [R21]
      next_r.st = r.d_last ? (r.d_chk ? S_CRC1 : S_IDLE) : S_NEXT;  // [R1] [R6]
    end

    // Clear-to-send negated while a message is under way
    if (r.cts_s[1] && !r.cts_s[2] && r.st != S_IDLE)
    begin
      next_r.ct_pend = 1'b1;
      ev_set[EV_TXE] = 1'b1;  // [R18]
    end
    ev_set[EV_CTS] = ev_set[EV_CTS] | (r.cts_s[1] ^ r.cts_s[2]);  // [R17]
    ev_set[EV_CD]  = r.cd_s[1] ^ r.cd_s[2];  // [R17]
    ev_set[EV_RCH] = rx_char_stored;  // [R19]
    ev_set[EV_BSY] = rx_char_dropped;  // [R20]
    ev_set[EV_RX]  = rx_buffer_closed;  // [R21]
    if (rx_char_dropped)
    begin
      next_r.rx_stopped = 1'b1;  // [R20]
    end
    else if (enter_hunt)
    begin
      next_r.rx_stopped = 1'b0;
    end
    next_r.rts_n = !(r.ctrl[CTRL_SYNC_FILL_SELECT] || next_r.st != S_IDLE);

    // Register bus: address and data accepted in either order
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_r.aw_got  = 1'b1;
      next_r.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_r.w_got = 1'b1;
      next_r.wdata = s_axi_wdata;
      next_r.wstrb = s_axi_wstrb;
    end
    if (r.bvalid && s_axi_bready)
    begin
      next_r.bvalid = 1'b0;
    end
    if (r.aw_got && r.w_got)
    begin
      next_r.aw_got = 1'b0;
      next_r.w_got  = 1'b0;
      next_r.bvalid = 1'b1;
      next_r.bresp  = RESP_OKAY;
      if (r.aw_addr == ADDR_EVENT)
      begin
        ev_clr = r.wdata[7:0] & {8{r.wstrb[0]}};  // [R14]
      end
      else if (r.aw_addr == ADDR_MASK)
      begin
        wr = bstx_merge({24'h0, r.mask}, r.wdata, r.wstrb);
        next_r.mask = wr[7:0];  // [R22]
      end
      else if (r.aw_addr == ADDR_CTRL)
      begin
        wr = bstx_merge({29'h0, r.ctrl}, r.wdata, r.wstrb);
        next_r.ctrl = wr[CTRL_W-1:0];
      end
      else if (r.aw_addr == ADDR_CHARS)
      begin
        wr = bstx_merge({8'h0, r.chars}, r.wdata, r.wstrb);
        next_r.chars = wr[23:0];
      end
      else if (r.aw_addr == ADDR_TCRC)
      begin
        wr = bstx_merge({16'h0, next_r.crc}, r.wdata, r.wstrb);
        next_r.crc = wr[15:0];  // [R9]
      end
      else if (r.aw_addr != ADDR_STATUS)
      begin
        next_r.bresp = RESP_SLVERR;
      end
    end
    if (r.rvalid && s_axi_rready)
    begin
      next_r.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready)
    begin
      next_r.rvalid = 1'b1;
      next_r.rresp  = RESP_OKAY;
      next_r.rdata  = 32'h0;
      if (s_axi_araddr == ADDR_EVENT)
      begin
        next_r.rdata[7:0] = r.ev;  // [R13]
      end
      else if (s_axi_araddr == ADDR_MASK)
      begin
        next_r.rdata[7:0] = r.mask;
      end
      else if (s_axi_araddr == ADDR_CTRL)
      begin
        next_r.rdata[CTRL_W-1:0] = r.ctrl;
      end
      else if (s_axi_araddr == ADDR_CHARS)
      begin
        next_r.rdata[23:0] = r.chars;
      end
      else if (s_axi_araddr == ADDR_TCRC)
      begin
        next_r.rdata[15:0] = r.crc;
      end
      else if (s_axi_araddr == ADDR_STATUS)
      begin
        next_r.rdata[STS_CTS]  = !r.cts_s[2];
        next_r.rdata[STS_CD]   = !r.cd_s[2];
        next_r.rdata[STS_XMOD] = r.xmode;
        next_r.rdata[STS_RXST] = r.rx_stopped;
      end
      else
      begin
        next_r.rresp = RESP_SLVERR;
      end
    end
    // Set after clear so an event landing on its own clear is kept
    next_r.ev  = ((r.ev & ~ev_clr) | ev_set) & EV_IMPL;  // [R13] [R16] [R23]
    next_r.irq = |(next_r.ev & next_r.mask);  // [R15]
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      r <= '0;
      r.st     <= S_IDLE;
      r.ret    <= S_IDLE;
      r.bitcnt <= BIT_LAST;
      r.txd    <= 1'b1;
      r.sh     <= IDLE_CHAR;
      r.rts_n  <= 1'b1;
      r.tclk_s <= 3'h0;
      r.cts_s  <= 3'h7;
      r.cd_s   <= 3'h7;
      r.chars  <= CHARS_RESET;
      r.crc    <= CRC_PRESET;
    end
    else
    begin
      r <= next_r;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_check_clear;
    accept && check_clear_flag && !(r.aw_got && r.w_got) |=> r.crc == CRC_PRESET;
  endproperty
  a_check_clear: assert property (p_check_clear) else $error("check clear missed");  // [R3]

  property p_auto_escape;
    accept && auto_escape_prefix |=> r.pend_dle ##1 (r.st == S_FILL2) [*1];
  endproperty
  a_auto_escape: assert property (p_auto_escape) else $error("escape prefix missed");  // [R4]

  property p_dle_double;
    load && r.st == S_DATA && !r.pend_dle && data_valid && r.xmode &&
      data_byte == r.chars[CH_DLE +: 8] |=> r.st == S_DUP;
  endproperty
  a_dle_double: assert property (p_dle_double) else $error("escape not doubled");  // [R7]

  property p_underrun;
    load && r.st == S_NEXT && !desc_valid |=> r.ev[EV_TXE] && r.un_pend &&
      r.last_byte == (r.xmode ? r.chars[CH_DLE +: 8] : r.chars[CH_SYNC1 +: 8]);
  endproperty
  a_underrun: assert property (p_underrun) else $error("underrun not handled");  // [R6]

  property p_crc_reset;
    load && r.st == S_CRC2 |=> r.crc == CRC_PRESET && r.st == S_IDLE;
  endproperty
  a_crc_reset: assert property (p_crc_reset) else $error("check not reset");  // [R1]

  property p_crc16_forced;
    load && r.st == S_CRC1 && r.use_crc |=> r.st == S_CRC2;
  endproperty
  a_crc16_forced: assert property (p_crc16_forced) else $error("crc16 short");  // [R8]

  property p_set_wins;
    ev_set[EV_TX] |=> r.ev[EV_TX];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost");  // [R23]

  property p_irq;
    |(r.ev & r.mask) |-> r.irq;
  endproperty
  a_irq: assert property (p_irq) else $error("irq dropped early");  // [R15]

  property p_w1c;
    (ev_clr[EV_RX] && !ev_set[EV_RX]) |=> !r.ev[EV_RX];
  endproperty
  a_w1c: assert property (p_w1c) else $error("clear failed");  // [R14]

  property p_busy;
    rx_char_dropped |=> r.ev[EV_BSY] && r.rx_stopped;
  endproperty
  a_busy: assert property (p_busy) else $error("busy not flagged");  // [R20]

  // A buffer needs at least the second sync byte and one data byte, 128 clocks each
  c_accept:   cover property (accept ##[1:1000] stat_valid);
  c_underrun: cover property (load && r.st == S_NEXT && !desc_valid);
  c_dup:      cover property (r.st == S_DUP);
endmodule

// file: design/bstx_pkg.sv
package bstx_pkg;
  // Register byte addresses
  localparam logic [7:0] ADDR_EVENT  = 8'h00;
  localparam logic [7:0] ADDR_MASK   = 8'h04;
  localparam logic [7:0] ADDR_CTRL   = 8'h08;
  localparam logic [7:0] ADDR_CHARS  = 8'h0c;
  localparam logic [7:0] ADDR_TCRC   = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  // Event and mask bit positions
  localparam int EV_CTS  = 7;
  localparam int EV_CD   = 6;
  localparam int EV_TXE  = 4;
  localparam int EV_RCH  = 3;
  localparam int EV_BSY  = 2;
  localparam int EV_TX   = 1;
  localparam int EV_RX   = 0;
  localparam logic [7:0] EV_IMPL = 8'hdf;
  // Control register fields
  localparam int CTRL_EN   = 0;
  localparam int CTRL_SYNC_FILL_SELECT = 1;
  localparam int CTRL_LRC  = 2;
  localparam int CTRL_W    = 3;
  // Character register fields: sync1 [7:0], sync2 [15:8], escape [23:16]
  localparam int CH_SYNC1 = 0;
  localparam int CH_SYNC2 = 8;
  localparam int CH_DLE   = 16;
  localparam logic [23:0] CHARS_RESET = 24'h103232;
  // Status register fields
  localparam int STS_CTS  = 0;
  localparam int STS_CD   = 1;
  localparam int STS_XMOD = 2;
  localparam int STS_RXST = 3;
  // Line fill and block check
  localparam logic [7:0]  IDLE_CHAR  = 8'hff;
  localparam logic [15:0] CRC_PRESET = 16'h0000;
  localparam logic [15:0] CRC_POLY   = 16'ha001;
  localparam logic [2:0]  BIT_LAST   = 3'h7;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    S_IDLE,
    S_DATA,
    S_DUP,
    S_NEXT,
    S_CRC1,
    S_CRC2,
    S_FILL2
  } bstx_st_e;
endpackage

// file: sim/bstx_remote.sv
`timescale 1ns/1ps
// Remote modem: supplies the transmit clock; clear-to-send and carrier follow the bench
module bstx_remote
(
  input  wire logic        txd,
  input  wire logic        cd_off,
  input  wire logic        cts_off,
  output logic             tclk,
  output logic             cts_n,
  output logic             cd_n,
  output logic [15:0]      last_two
);
  // The transmitter fills idle time itself, so the modem clock runs free
  initial
  begin
    tclk = 1'b0;
    #7;
    forever #32 tclk = ~tclk;
  end
  assign cts_n = cts_off;
  assign cd_n  = cd_off;
  initial last_two = 16'hffff;
  // LSB first: the older byte ends up in the low half
  always @(posedge tclk) last_two <= {txd, last_two[15:1]};
endmodule

// file: sim/bisync_tx_descriptor_events_tb.sv
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin fails++; \
  $display("BAD t=%0t got %h exp %h", $time, a, e); end end
module bisync_tx_descriptor_events_tb;
  import bstx_pkg::*;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr, data_byte;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb, rx_ev;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic desc_valid, desc_ready, desc_last, send_check_after_last, desc_check_enable;
  logic check_clear_flag, auto_escape_prefix, transparent_flag, data_valid, data_ready;
  logic stat_valid, underrun_status, clear_to_send_lost, tclk, txd, rts_n, cts_n, cd_n;
  logic rx_stopped, irq, cd_off, cts_off;
  logic [15:0] desc_length, last_two, crc;
  logic [31:0] d;
  int fails, n_checks;
  wire [2:0] hs = {stat_valid, data_ready, desc_ready};

  bstx_top i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .desc_valid, .desc_ready, .desc_length, .desc_last, .send_check_after_last,
    .desc_check_enable, .check_clear_flag, .auto_escape_prefix, .transparent_flag, .data_valid,
    .data_ready, .data_byte, .stat_valid, .underrun_status, .clear_to_send_lost, .tclk, .txd,
    .rts_n, .cts_n, .cd_n, .rx_char_stored(rx_ev[0]), .rx_char_dropped(rx_ev[1]),
    .rx_buffer_closed(rx_ev[2]), .enter_hunt(rx_ev[3]), .rx_stopped, .irq);
  bstx_remote i_remote (.txd, .cd_off, .cts_off, .tclk, .cts_n, .cd_n, .last_two);

  initial
  begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  task automatic wrap_up();
    $display("checks=%0d fails=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
    s_axi_awaddr <= a; s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    // One idle edge so a following call never drives bready twice in a step
    @(posedge aclk);
  endtask

  task automatic axi_rd(input logic [7:0] a);
    s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid);
    d = s_axi_rdata; r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    axi_rd(a);
    `CHK(d & m, e)
  endtask

  task automatic pulse(input int k);
    rx_ev <= 4'h1 << k;
    @(posedge aclk);
    rx_ev <= 4'h0;
    repeat (3) @(posedge aclk);
  endtask

  // Handshake pulses last one cycle, so they are looked at mid-cycle
  task automatic wait_hs(input int k);
    for (int i = 0; i < 3000; i++)
    begin
      @(negedge aclk);
      if (hs[k]) break;
    end
    `CHK(hs[k], 1'b1)
  endtask

  task automatic send_buf(input logic [5:0] f, input int n, input logic [15:0] b);
    @(posedge aclk);
    {desc_last, send_check_after_last, desc_check_enable} <= f[5:3];
    {check_clear_flag, auto_escape_prefix, transparent_flag} <= f[2:0];
    desc_length <= n[15:0]; desc_valid <= 1'b1; data_valid <= 1'b1; data_byte <= b[7:0];
    wait_hs(0);
    @(posedge aclk);
    desc_valid <= 1'b0;
    for (int i = 0; i < n; i++)
    begin
      wait_hs(1);
      @(posedge aclk);
      data_byte <= b[15:8];
      if (i == n - 1) data_valid <= 1'b0;
    end
    wait_hs(2);
  endtask

  // Bit-level hunt: the link gives no byte alignment of its own
  task automatic expect_pair(input logic [7:0] b0, input logic [7:0] b1);
    for (int i = 0; i < 120; i++)
    begin
      @(posedge tclk);
      #1;
      if (last_two === {b1, b0}) break;
    end
    `CHK(last_two, {b1, b0})
  endtask

  function automatic logic [15:0] crc16(input logic [15:0] b, input int n);
    logic [15:0] c;
    c = CRC_PRESET;
    for (int i = 0; i < n; i++)
    begin
      c ^= {8'h00, b[8*i +: 8]};
      for (int j = 0; j < 8; j++)
        c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction

  initial
  begin
    #200000;
    fails++;
    wrap_up();
  end

  initial
  begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, rx_ev, desc_valid, data_valid} = '0;
    {desc_last, send_check_after_last, desc_check_enable, check_clear_flag} = '0;
    {auto_escape_prefix, transparent_flag, data_byte, desc_length, cd_off, cts_off} = '0;
    s_axi_wstrb = 4'hf;
    fails = 0;
    n_checks = 0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd_chk(ADDR_EVENT, 32'h3f, 32'h0);
    rd_chk(ADDR_MASK, 32'hff, 32'h0);
    axi_rd(8'h3c);
    `CHK(r, RESP_SLVERR)
    axi_wr(ADDR_EVENT, 32'hff);
    axi_wr(ADDR_MASK, 32'h02);
    `CHK(r, RESP_OKAY)
    rd_chk(ADDR_MASK, 32'hff, 32'h02);
    pulse(0);
    rd_chk(ADDR_EVENT, 32'h2f, 32'h08);
    pulse(2);
    rd_chk(ADDR_EVENT, 32'h2f, 32'h09);
    pulse(1);
    rd_chk(ADDR_EVENT, 32'h2f, 32'h0d);
    `CHK(rx_stopped, 1'b1)
    `CHK(irq, 1'b0)
    pulse(3);
    `CHK(rx_stopped, 1'b0)
    axi_wr(ADDR_EVENT, 32'h00);
    rd_chk(ADDR_EVENT, 32'h0f, 32'h0d);
    axi_wr(ADDR_EVENT, 32'h0d);
    rd_chk(ADDR_EVENT, 32'h0f, 32'h00);
    cd_off <= 1'b1;
    repeat (8) @(posedge aclk);
    rd_chk(ADDR_EVENT, 32'h40, 32'h40);
    cd_off <= 1'b0;
    repeat (8) @(posedge aclk);
    rd_chk(ADDR_STATUS, 32'h3, 32'h3);
    axi_wr(ADDR_EVENT, 32'hff);
    axi_wr(ADDR_CTRL, 32'h1);
    send_buf(6'b111100, 2, 16'h1041);
    expect_pair(8'h41, 8'h10);
    crc = crc16(16'h1041, 2);
    expect_pair(crc[7:0], crc[15:8]);
    `CHK(underrun_status, 1'b0)
    `CHK(clear_to_send_lost, 1'b0)
    rd_chk(ADDR_EVENT, 32'h12, 32'h02);
    repeat (2) @(posedge aclk);
    `CHK(irq, 1'b1)
    axi_wr(ADDR_EVENT, 32'h02);
    repeat (2) @(posedge aclk);
    `CHK(irq, 1'b0)
    axi_wr(ADDR_TCRC, {16'h0, CRC_PRESET});
    axi_wr(ADDR_CTRL, 32'h5);
    send_buf(6'b000011, 1, 16'h0055);
    expect_pair(8'h10, 8'h55);
    expect_pair(8'h10, 8'h32);
    rd_chk(ADDR_EVENT, 32'h10, 32'h10);
    send_buf(6'b111100, 1, 16'h0010);
    expect_pair(8'h10, 8'h10);
    crc = crc16(16'h0010, 1);
    expect_pair(crc[7:0], crc[15:8]);
    `CHK(underrun_status, 1'b1)
    send_buf(6'b000000, 1, 16'h0010);
    expect_pair(8'h32, 8'h32);
    `CHK(rts_n, 1'b0)
    // Clear-to-send drops while the underrun fill is on the line
    @(posedge aclk);
    cts_off <= 1'b1;
    repeat (8) @(posedge aclk);
    rd_chk(ADDR_EVENT, 32'h80, 32'h80);
    send_buf(6'b100000, 1, 16'h0033);
    `CHK(clear_to_send_lost, 1'b1)
    `CHK(rts_n, 1'b1)
    wrap_up();
  end
endmodule
